// ==== core/rda_map.svh ====
// register map, field layout and timing constants
// Functional notes
// - year holds BCD tens and ones digits
// - year writes need write unlock set
// - month tens bit 12, ones 11:8
// - day tens bits 5:4, ones 3:0
// - month/day writes need write unlock set
// - alarm minute tens 14:12, ones 11:8
// - alarm second tens 6:4, ones 3:0
// - unimplemented value bits read zero
// - signed calibration applied once per minute
// - each step is four pulses, sign selects
`ifndef RDA_MAP_SVH
`define RDA_MAP_SVH
`define RDA_ADDR_W        12
`define RDA_OFF_YEAR      12'h000
`define RDA_OFF_MONTH_DAY 12'h004
`define RDA_OFF_ALARM     12'h008
`define RDA_OFF_CFG       12'h00C
`define RDA_OFF_STATUS    12'h010
`define RDA_YEAR_MASK     16'h00FF
`define RDA_MD_MASK       16'h1F3F
`define RDA_ALARM_MASK    16'h7F7F
`define RDA_VALUE_RESET   16'h0000
`define RDA_CAL_RESET     8'h00
`define RDA_CFG_CAL       7:0
`define RDA_CFG_UNLOCK    13
`define RDA_CFG_ON        15
`define RDA_ST_SECONDS    5:0
`define RDA_ST_INSERT     8
`define RDA_ST_SKIP       9
`define RDA_ST_LEFT       25:16
`define RDA_TICKS_PER_SEC 32768
`define RDA_SEC_PER_MIN   60
`define RDA_CAL_SHIFT     2
`define RDA_STEP_ONE      1
`define RDA_STEP_INS      2
`endif

// ==== core/rda_pkg.sv ====
// shared types for the date, alarm and calibration block
package rda_pkg;
  typedef enum logic [1:0] {RDA_IDLE, RDA_ADD, RDA_SUB} rda_adj_type;
  typedef logic [15:0] rda_word_type;
endpackage : rda_pkg

// ==== core/rda_sec_timer.sv ====
// crystal prescaler with seconds and minute pulses
`timescale 1ns/10ps
`include "rda_map.svh"
module rda_sec_timer #(
  parameter int TICKS = `RDA_TICKS_PER_SEC
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic       insert,
  input  wire logic       skip,
  output logic      [5:0] seconds,
  output logic            sec_pulse,
  output logic            min_pulse
);
  localparam int CW = $clog2(TICKS) + 1;
  logic [CW-1:0] count;
  wire           live = run && tick && !skip;
  wire  [CW-1:0] step = live ? (insert ? CW'(`RDA_STEP_INS) : CW'(`RDA_STEP_ONE)) : '0;
  wire  [CW-1:0] sum  = count + step;
  wire           wrap = sum >= CW'(TICKS);
  wire           last = seconds == 6'(`RDA_SEC_PER_MIN - 1);
  wire  [CW-1:0] next_count = wrap ? sum - CW'(TICKS) : sum;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count     <= '0;
      seconds   <= '0;
      sec_pulse <= 1'b0;
      min_pulse <= 1'b0;
    end else begin
      count     <= next_count;
      sec_pulse <= wrap;
      min_pulse <= wrap && last;
      if (wrap) begin
        seconds <= last ? 6'h00 : seconds + 6'h01;
      end
    end
  end
endmodule : rda_sec_timer

// ==== core/rda_cal_adjust.sv ====
// per-minute pulse insert or skip sequencer
`timescale 1ns/10ps
`include "rda_map.svh"
module rda_cal_adjust (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic       start,
  input  wire logic [7:0] cal,
  output logic            insert,
  output logic            skip,
  output logic      [9:0] left
);
  rda_pkg::rda_adj_type state;
  rda_pkg::rda_adj_type next_state;
  wire       neg  = cal[7];
  wire [7:0] mag  = neg ? 8'(-cal) : cal;
  wire [9:0] load = 10'(mag) << `RDA_CAL_SHIFT;
  wire       idle = state == rda_pkg::RDA_IDLE;
  wire       go   = run && start && idle && cal != `RDA_CAL_RESET;
  wire       done = tick && left == 10'h001;

  always_comb begin
    next_state = state;
    unique case (state)
      rda_pkg::RDA_IDLE: if (go) next_state = neg ? rda_pkg::RDA_SUB : rda_pkg::RDA_ADD;
      rda_pkg::RDA_ADD,
      rda_pkg::RDA_SUB:  if (!run || done) next_state = rda_pkg::RDA_IDLE;
    endcase
  end

  assign insert = state == rda_pkg::RDA_ADD;
  assign skip   = state == rda_pkg::RDA_SUB;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= rda_pkg::RDA_IDLE;
      left  <= '0;
    end else begin
      state <= next_state;
      if (go) begin
        left <= load;
      end else if (!run) begin
        left <= '0;
      end else if (tick && !idle) begin
        left <= left - 10'h001;
      end
    end
  end
endmodule : rda_cal_adjust

// ==== core/rda_top.sv ====
// date, alarm value and crystal calibration block with apb slave
`timescale 1ns/10ps
`include "rda_map.svh"
module rda_top #(
  parameter int TICKS = `RDA_TICKS_PER_SEC
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`RDA_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   crystal_tick,
  output logic                        seconds_pulse,
  output logic                        minute_pulse,
  output logic                        timer_on,
  output logic                        clock_write_unlock
);
  rda_pkg::rda_word_type year_value;
  rda_pkg::rda_word_type month_day_value;
  rda_pkg::rda_word_type alarm_minute_second_value;
  logic [7:0]            clock_config_calibration;

  // timer side
  logic [5:0] seconds;
  logic       sec_pulse;
  logic       min_pulse;
  logic       adj_insert;
  logic       adj_skip;
  logic [9:0] adj_left;

  rda_sec_timer #(
    .TICKS (TICKS)
  ) u_timer (
    .pclk      (pclk),
    .presetn   (presetn),
    .run       (timer_on),
    .tick      (crystal_tick),
    .insert    (adj_insert),
    .skip      (adj_skip),
    .seconds   (seconds),
    .sec_pulse (sec_pulse),
    .min_pulse (min_pulse)
  );

  rda_cal_adjust u_adjust (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (timer_on),
    .tick    (crystal_tick),
    .start   (min_pulse),
    .cal     (clock_config_calibration),
    .insert  (adj_insert),
    .skip    (adj_skip),
    .left    (adj_left)
  );

  assign seconds_pulse = sec_pulse;
  assign minute_pulse  = min_pulse;

  // bus phases
  wire setup  = psel && !penable;
  wire access = psel && penable && pready;
  wire wr_en  = access && pwrite;

  // address decode
  wire hit_year   = paddr == `RDA_OFF_YEAR;
  wire hit_md     = paddr == `RDA_OFF_MONTH_DAY;
  wire hit_alarm  = paddr == `RDA_OFF_ALARM;
  wire hit_cfg    = paddr == `RDA_OFF_CFG;
  wire hit_status = paddr == `RDA_OFF_STATUS;
  wire mapped     = hit_year || hit_md || hit_alarm || hit_cfg || hit_status;

  // write enables, date registers gated by the unlock bit
  wire wr_year  = wr_en && hit_year && clock_write_unlock;
  wire wr_md    = wr_en && hit_md && clock_write_unlock;
  wire wr_alarm = wr_en && hit_alarm;
  wire wr_cfg   = wr_en && hit_cfg;

  // stored values keep only implemented digit bits
  wire [15:0] next_year  = pwdata[15:0] & `RDA_YEAR_MASK;
  wire [15:0] next_md    = pwdata[15:0] & `RDA_MD_MASK;
  wire [15:0] next_alarm = pwdata[15:0] & `RDA_ALARM_MASK;

  // read words
  wire [31:0] rd_year   = {16'h0000, year_value};
  wire [31:0] rd_md     = {16'h0000, month_day_value};
  wire [31:0] rd_alarm  = {16'h0000, alarm_minute_second_value};
  wire [31:0] rd_cfg    = {16'h0000, timer_on, 1'b0, clock_write_unlock, 5'h00, clock_config_calibration};
  wire [31:0] rd_status = {6'h00, adj_left, 6'h00, adj_skip, adj_insert, 2'h0, seconds};

  wire [31:0] read_word = hit_year   ? rd_year   :
                          hit_md     ? rd_md     :
                          hit_alarm  ? rd_alarm  :
                          hit_cfg    ? rd_cfg    :
                          hit_status ? rd_status : 32'h0000_0000;

  wire [31:0] next_rdata = (setup && !pwrite) ? read_word : 32'h0000_0000;

  // bus answer, one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= next_rdata;
    end
  end

  // date registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      year_value      <= `RDA_VALUE_RESET;
      month_day_value <= `RDA_VALUE_RESET;
    end else begin
      if (wr_year) begin
        year_value <= next_year;
      end
      if (wr_md) begin
        month_day_value <= next_md;
      end
    end
  end

  // alarm value register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_minute_second_value <= `RDA_VALUE_RESET;
    end else if (wr_alarm) begin
      alarm_minute_second_value <= next_alarm;
    end
  end

  // configuration and calibration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_config_calibration <= `RDA_CAL_RESET;
      clock_write_unlock       <= 1'b0;
      timer_on                 <= 1'b0;
    end else if (wr_cfg) begin
      clock_config_calibration <= pwdata[`RDA_CFG_CAL];
      clock_write_unlock       <= pwdata[`RDA_CFG_UNLOCK];
      timer_on                 <= pwdata[`RDA_CFG_ON];
    end
  end

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire [7:0] cal_mag  = clock_config_calibration[7] ? 8'(-clock_config_calibration) : clock_config_calibration;
  wire [9:0] cal_load = 10'(cal_mag) << `RDA_CAL_SHIFT;
  wire       adj_idle = !adj_insert && !adj_skip;

  sequence s_locked_wr(hit);
    wr_en && hit && !clock_write_unlock;
  endsequence

  sequence s_read_setup(hit);
    setup && !pwrite && hit;
  endsequence

  sequence s_cal_start;
    min_pulse && timer_on && adj_idle && clock_config_calibration != `RDA_CAL_RESET;
  endsequence

  sequence s_clean_answer;
    pready && !pslverr;
  endsequence

  sequence s_live_tick;
    timer_on && crystal_tick;
  endsequence

  // ticks spent in the current adjust
  logic [9:0] adj_ticks;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adj_ticks <= '0;
    end else if (adj_idle) begin
      adj_ticks <= '0;
    end else if (timer_on && crystal_tick) begin
      adj_ticks <= adj_ticks + 10'h001;
    end
  end

  a_year_guard: assert property (s_locked_wr(hit_year) |=> $stable(year_value))
    else $error("locked year write changed the year");

  a_year_store: assert property (wr_year |=> year_value == $past(next_year))
    else $error("unlocked year write not stored");

  a_md_guard: assert property (s_locked_wr(hit_md) |=> $stable(month_day_value))
    else $error("locked month/day write changed the value");

  a_unused_zero: assert property (
    ((year_value & ~`RDA_YEAR_MASK) == 16'h0000) &&
    ((month_day_value & ~`RDA_MD_MASK) == 16'h0000) &&
    ((alarm_minute_second_value & ~`RDA_ALARM_MASK) == 16'h0000))
    else $error("unimplemented value bit set");

  a_md_read: assert property (s_read_setup(hit_md) |=> pready
    && prdata[12:8] == month_day_value[12:8] && prdata[5:0] == month_day_value[5:0]
    && prdata[31:13] == 19'h00000 && prdata[7:6] == 2'h0)
    else $error("month/day read word malformed");

  a_alarm_read: assert property (s_read_setup(hit_alarm) |=> pready
    && prdata[15:0] == alarm_minute_second_value && prdata[31:16] == 16'h0000
    && prdata[15] == 1'b0 && prdata[7] == 1'b0)
    else $error("alarm read word mismatch");

  a_cal_load: assert property (s_cal_start |=> adj_left == $past(cal_load))
    else $error("calibration count not four times the value");

  a_cal_sign: assert property (s_cal_start |=> (adj_skip == $past(clock_config_calibration[7]))
    && (adj_insert == !$past(clock_config_calibration[7])))
    else $error("calibration direction wrong");

  a_cal_drain: assert property ((adj_insert || adj_skip) && timer_on && crystal_tick
    && adj_left > 10'h001 |=> adj_left == $past(adj_left) - 10'h001)
    else $error("calibration pulse count not decremented");

  a_apb_ready: assert property (setup |=> pready ##1 !pready)
    else $error("access phase answer not one cycle");

  // register storage checks
  a_md_store: assert property (wr_md |=> month_day_value == $past(next_md))
    else $error("unlocked month/day write not stored");

  a_alarm_store: assert property (wr_alarm |=> alarm_minute_second_value == $past(next_alarm))
    else $error("alarm write not stored");

  a_year_hold: assert property (!wr_year |=> $stable(year_value))
    else $error("year changed without a write");

  a_md_hold: assert property (!wr_md |=> $stable(month_day_value))
    else $error("month/day changed without a write");

  a_alarm_hold: assert property (!wr_alarm |=> $stable(alarm_minute_second_value))
    else $error("alarm changed without a write");

  a_cfg_store: assert property (wr_cfg |=> clock_config_calibration == $past(pwdata[`RDA_CFG_CAL])
    && clock_write_unlock == $past(pwdata[`RDA_CFG_UNLOCK]) && timer_on == $past(pwdata[`RDA_CFG_ON]))
    else $error("configuration write not stored");

  a_cal_hold: assert property (!wr_cfg |=> $stable(clock_config_calibration)
    && $stable(clock_write_unlock) && $stable(timer_on))
    else $error("configuration changed without a write");

  a_unmapped_hold: assert property (wr_en && !mapped |=> $stable(year_value)
    && $stable(month_day_value) && $stable(alarm_minute_second_value) && $stable(clock_config_calibration))
    else $error("unmapped write changed a register");

  // bus answer checks
  a_year_read: assert property (s_read_setup(hit_year) |=> s_clean_answer ##0
    (prdata[7:0] == year_value[7:0] && prdata[31:8] == 24'h000000))
    else $error("year read word malformed");

  a_cfg_read: assert property (s_read_setup(hit_cfg) |=>
    prdata[`RDA_CFG_CAL] == clock_config_calibration
    && prdata[`RDA_CFG_UNLOCK] == clock_write_unlock && prdata[`RDA_CFG_ON] == timer_on
    && prdata[31:16] == 16'h0000)
    else $error("configuration read word mismatch");

  a_status_read: assert property (s_read_setup(hit_status) |=>
    prdata[`RDA_ST_SECONDS] == $past(seconds) && prdata[`RDA_ST_LEFT] == $past(adj_left)
    && prdata[`RDA_ST_INSERT] == $past(adj_insert) && prdata[`RDA_ST_SKIP] == $past(adj_skip))
    else $error("status read word mismatch");

  a_unmapped_err: assert property (setup && !mapped |=> pready && pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  a_mapped_ok: assert property (setup && mapped |=> s_clean_answer)
    else $error("mapped access flagged as error");

  a_locked_noerr: assert property (setup && pwrite && !clock_write_unlock
    && (hit_year || hit_md) |=> s_clean_answer)
    else $error("locked date write flagged as error");

  a_err_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");

  a_ready_setup: assert property (pready |-> $past(setup))
    else $error("ready without a setup cycle");

  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("read data outside access cycle");

  a_wr_rdata: assert property (setup && pwrite |=> prdata == 32'h0000_0000)
    else $error("read data driven on a write");

  // calibration sequencer checks
  a_adj_excl: assert property (!(adj_insert && adj_skip))
    else $error("insert and skip both active");

  a_adj_cancel: assert property (!timer_on |=> adj_idle && adj_left == 10'h000)
    else $error("adjust kept running with timer off");

  a_adj_end: assert property (s_live_tick ##0 (!adj_idle && adj_left == 10'h001)
    |=> adj_idle && adj_left == 10'h000)
    else $error("adjust did not end on its last pulse");

  a_adj_ignore: assert property (s_live_tick ##0 (!adj_idle && adj_left > 10'h001)
    |=> !adj_idle)
    else $error("adjust ended early");

  a_cal_zero: assert property (min_pulse && timer_on && adj_idle
    && clock_config_calibration == `RDA_CAL_RESET |=> adj_idle)
    else $error("zero calibration started an adjust");

  a_left_idle: assert property (adj_idle |-> adj_left == 10'h000)
    else $error("pulses left while idle");

  a_left_live: assert property (!adj_idle |-> adj_left != 10'h000)
    else $error("adjust active with no pulses left");

  a_adj_wait: assert property (!adj_idle && timer_on && !crystal_tick
    |=> $stable(adj_left) && $stable(adj_insert) && $stable(adj_skip))
    else $error("adjust moved without a tick");

  a_adj_total: assert property (!adj_idle && $past(!adj_idle)
    |-> adj_ticks + adj_left == $past(adj_ticks + adj_left))
    else $error("adjust pulse total changed");

  // seconds timer checks
  a_sec_range: assert property (seconds < 6'(`RDA_SEC_PER_MIN))
    else $error("seconds count out of range");

  a_min_pair: assert property (min_pulse |-> sec_pulse && seconds == 6'h00)
    else $error("minute pulse without second rollover");

  a_sec_count: assert property (sec_pulse && !min_pulse |-> seconds != 6'h00)
    else $error("second pulse without count step");

  a_sec_tick: assert property (sec_pulse |-> $past(crystal_tick && timer_on && !adj_skip))
    else $error("second pulse without a counted tick");

  a_timer_off: assert property (!timer_on |=> !sec_pulse && $stable(seconds))
    else $error("timer counted while off");

  a_skip_tick: assert property (s_live_tick ##0 adj_skip |=> !sec_pulse && $stable(seconds))
    else $error("skipped tick was counted");

endmodule : rda_top

// ==== bench/tb_top.sv ====
// self-checking bench for the date, alarm and calibration block
`timescale 1ns/10ps
`include "rda_map.svh"
module tb_top;
  // minute length kept above twice the largest insert
  localparam int TK    = 20;
  localparam int MIN_T = TK * `RDA_SEC_PER_MIN;
  logic        pclk, presetn, psel, penable, pwrite, crystal_tick, tick_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, r;
  logic        pready, pslverr, seconds_pulse, minute_pulse, timer_on, clock_write_unlock;
  logic [1:0]  tcnt;
  logic [32:0] exp_q[$];
  int          min_q[$];
  int          err_total, n_checks, ticks, a;
  logic signed [7:0] cals[5] = '{8'sd3, -8'sd2, 8'sd127, 8'sh80, 8'sd0};

  rda_top #(.TICKS(TK)) rda_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_tick(crystal_tick), .seconds_pulse(seconds_pulse), .minute_pulse(minute_pulse),
    .timer_on(timer_on), .clock_write_unlock(clock_write_unlock));

  always #20 pclk = ~pclk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic results();
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  task automatic chk(input string name, input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    exp_q.push_back(e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      results();
    end
  endtask : apb

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b0, ad, 32'h0, {1'b0, d});
  endtask : rd

  task automatic idle();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : idle

  task automatic wait_min();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (minute_pulse !== 1'b1 && n < 30000);
    if (n >= 30000) begin
      err_total++;
      results();
    end
  endtask : wait_min

  // crystal ticks every fourth cycle while enabled
  always @(posedge pclk) begin
    tcnt         <= tcnt + 2'd1;
    crystal_tick <= tick_en && (tcnt == 2'd3);
  end

  // scoreboard: bus answers and minute lengths
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) chk("apb extra", 33'h0, 33'h1);
      else chk("apb", {pslverr, prdata}, exp_q.pop_front());
    end
    if (minute_pulse === 1'b1) begin
      chk("pair", {32'h0, seconds_pulse}, 33'h1);
      if (min_q.size() > 0) chk("minute", 33'(ticks), 33'(min_q.pop_front()));
      ticks = 0;
    end else if (crystal_tick && timer_on) ticks++;
  end

  initial begin
    pclk = 1'b0;
    {psel, penable, pwrite, crystal_tick, tick_en} = '0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    seed = 32'hdaa7;
    tcnt = '0;
    err_total = 0;
    n_checks = 0;
    ticks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`RDA_OFF_CFG, 32'h0);
    rd(`RDA_OFF_STATUS, 32'h0);
    wr(`RDA_OFF_YEAR, 32'h99);
    rd(`RDA_OFF_YEAR, 32'h0);
    wr(`RDA_OFF_MONTH_DAY, 32'h1234);
    rd(`RDA_OFF_MONTH_DAY, 32'h0);
    wr(`RDA_OFF_CFG, 32'h2000);
    repeat (4) begin
      r = xs();
      wr(`RDA_OFF_YEAR, r);
      rd(`RDA_OFF_YEAR, r & 32'(`RDA_YEAR_MASK));
      wr(`RDA_OFF_MONTH_DAY, r);
      rd(`RDA_OFF_MONTH_DAY, r & 32'(`RDA_MD_MASK));
      wr(`RDA_OFF_ALARM, r);
      rd(`RDA_OFF_ALARM, r & 32'(`RDA_ALARM_MASK));
    end
    apb(1'b1, 12'h014, r, 33'h1_0000_0000);
    apb(1'b0, 12'h014, 32'h0, 33'h1_0000_0000);
    idle();
    chk("unlock", {32'h0, clock_write_unlock}, 33'h1);
    foreach (cals[i]) begin
      a = (cals[i] < 0) ? -int'(cals[i]) : int'(cals[i]);
      wr(`RDA_OFF_CFG, {16'h0, 8'hA0, cals[i]});
      idle();
      chk("timer on", {32'h0, timer_on}, 33'h1);
      tick_en <= 1'b1;
      wait_min();
      tick_en <= 1'b0;
      rd(`RDA_OFF_STATUS, {6'h0, 10'(4 * a), 6'h0, 1'(cals[i] < 0), 1'(cals[i] > 0), 8'h0});
      idle();
      min_q.push_back(MIN_T - 4 * int'(cals[i]));
      tick_en <= 1'b1;
      wait_min();
      tick_en <= 1'b0;
      wr(`RDA_OFF_CFG, 32'h2000);
      idle();
    end
    repeat (4) @(posedge pclk);
    results();
  end
endmodule : tb_top
